// *** rtl/cfs_pkg.sv ***
// shared constants, types and register map of the converter fault supervisor
package cfs_pkg;

  // ****************************************
  // clock and fault timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned T_SUPPLY_NS = 1000;
  localparam int unsigned T_THERM_NS = 18000;
  localparam int unsigned T_OVP_NS = 100000;
  localparam int unsigned T_VSOV_NS = 20000;
  localparam int unsigned T_LINE_NS = 2000000;
  localparam int unsigned LEADING_EDGE_BLANKING_NS = 160;
  localparam int unsigned T_HOC_NS = 150;

  // least times round up, the hard overcurrent window rounds down
  localparam int unsigned CYC_SUPPLY = (T_SUPPLY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_THERM = (T_THERM_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_OVP = (T_OVP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_VSOV = (T_VSOV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_LINE = (T_LINE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_LEB = (LEADING_EDGE_BLANKING_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_HOC = (T_HOC_NS * CLK_MHZ) / 1000;

  // restart delays have no printed figure
  localparam int unsigned CYC_RESTART = 250000;
  localparam int unsigned CYC_RESTART_FAST = 2500;

  // line blanking shortened by this ratio at the higher line frequency
  localparam int unsigned LINE60_NUM = 5;
  localparam int unsigned LINE60_DEN = 6;

  localparam int unsigned CNT_W = 20;
  localparam int unsigned ON_W = 6;

  // ****************************************
  // fault filter indices, then extra event bits
  // ****************************************
  localparam int unsigned F_SUPLOW = 0;
  localparam int unsigned F_BELOWON = 1;
  localparam int unsigned F_SUPOV = 2;
  localparam int unsigned F_LSHORT = 3;
  localparam int unsigned F_BRIN = 4;
  localparam int unsigned F_BROUT = 5;
  localparam int unsigned F_LINEOV = 6;
  localparam int unsigned F_OVP = 7;
  localparam int unsigned F_THERM = 8;
  localparam int unsigned F_VSOV = 9;
  localparam int unsigned NF = 10;
  localparam int unsigned EV_PEAK = 10;
  localparam int unsigned EV_HOC = 11;
  localparam int unsigned NEV = 12;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_SCALE_BIT = 1;
  localparam int unsigned STS_STATE_LSB = 0;
  localparam int unsigned STS_GATE_BIT = 4;
  localparam int unsigned STS_CUT_BIT = 5;
  localparam int unsigned STS_FAST_BIT = 6;
  localparam int unsigned STS_QUAL_LSB = 16;

  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [NEV-1:0] MASK_RST = 12'h000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_PRESTART = 3'b001,
    ST_SOFT = 3'b010,
    ST_RUN = 3'b011,
    ST_RESTART = 3'b100,
    ST_VSOFF = 3'b101
  } cfs_state_e;

  typedef struct packed {
    cfs_state_e st;
    logic [CNT_W-1:0] rst_cnt;
    logic fast;
    logic [ON_W-1:0] on_cnt;
    logic gate;
    logic cut;
    logic [1:0] ctrl;
    logic [NEV-1:0] irq_stat;
    logic [NEV-1:0] irq_mask;
    logic irq;
    logic ack;
    logic [31:0] rdat;
  } cfs_regs_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cfs_blank_s;

endpackage

// *** rtl/cfs_blank.sv ***
// blanking filter: qualifies one fault flag after it has held for a set count
`timescale 1ns/1ps
module cfs_blank
  import cfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flag_i,
  input wire logic arm_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic qual_o
);

  cfs_blank_s q;
  cfs_blank_s d;

  // any drop of the flag or of the arm restarts the interval
  always_comb begin
    d = q;
    if (!flag_i || !arm_i) begin
      d.cnt = '0;
    end else if (q.cnt < limit_i) begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // >= keeps a shortened limit valid while a count is already beyond it
  assign qual_o = flag_i && arm_i && (q.cnt >= limit_i);

endmodule

// *** rtl/cfs_supervisor.sv ***
// converter fault supervisor: blanking, state flow, gate enable and register slave
`timescale 1ns/1ps
// Operation
// RULE1 - a junction temperature trip held for its blanking time in any active state starts a timed restart.
// RULE2 - an output overvoltage held for its blanking time in soft start or run stops switching and starts a timed restart.
// RULE3 - a sense pin overvoltage held for its blanking time in soft start or run inhibits all gate switching.
// RULE4 - after a sense overvoltage shutdown the gate stays off until the sense voltage is below the lower restart level; thermal and supply-low exits skip it
// RULE5 - supply faults use 1 us blanking: too low resets always, below turn-on resets in pre-startup, overvoltage restarts.
// RULE6 - a peak overcurrent after leading-edge blanking in soft start or run ends the present gate pulse only.
// RULE7 - line faults use 2 ms blanking: brownin gives a fast restart, brownout and line overvoltage a timed one, a short too, which the code blanks for 1 us.
// RULE8 - the line blanking may be shortened according to the detected line frequency.
// RULE9 - the peak current comparator is ignored for the leading-edge blanking time after each gate turn-on.
// RULE10 - a hard overcurrent inside the short window after turn-on in soft start or run starts a timed restart.
// RULE11 - the restart level of the sense overvoltage lies below its shutdown level, giving hysteresis.
// RULE12 - every restart holds the gate off for the restart delay, then returns to pre-startup and soft start; a brownin fast restart uses RESTART_FAST_CYC.
module cfs_supervisor
  import cfs_pkg::*;
#(
  parameter int unsigned THERM_CYC = CYC_THERM,
  parameter int unsigned OVP_CYC = CYC_OVP,
  parameter int unsigned VSOV_CYC = CYC_VSOV,
  parameter int unsigned LINE_CYC = CYC_LINE,
  parameter int unsigned RESTART_CYC = CYC_RESTART,
  parameter int unsigned RESTART_FAST_CYC = CYC_RESTART_FAST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_low_level_i,
  input wire logic supply_turn_on_level_i,
  input wire logic supply_ov_i,
  input wire logic line_short_i,
  input wire logic brownin_low_i,
  input wire logic brownout_i,
  input wire logic line_ov_i,
  input wire logic line_60hz_i,
  input wire logic peak_current_limit_i,
  input wire logic hard_overcurrent_trip_i,
  input wire logic output_overvoltage_trip_i,
  input wire logic sense_overvoltage_off_level_i,
  input wire logic sense_overvoltage_on_level_i,
  input wire logic temp_trip_i,
  input wire logic pulse_request_i,
  input wire logic soft_start_done_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic gate_drive_out_o,
  output logic core_reset_o,
  output logic [2:0] state_o
);

  // ****************************************
  // blanking limits
  // ****************************************
  localparam int unsigned LINE60_CYC = LINE_CYC * LINE60_NUM / LINE60_DEN;

  cfs_regs_s q;
  cfs_regs_s d;

  logic [NF-1:0] flag;
  logic [NF-1:0] arm;
  logic [NF-1:0] qual;
  logic [CNT_W-1:0] lim [NF];
  logic line_scaled;

  // ****************************************
  // state decode
  // ****************************************
  logic st_pre;
  logic st_act;
  logic st_any;

  assign st_pre = (q.st == ST_PRESTART);
  assign st_act = (q.st == ST_SOFT) || (q.st == ST_RUN);
  assign st_any = st_pre || st_act || (q.st == ST_VSOFF);

  // RULE8 shorter line blanking
  assign line_scaled = q.ctrl[CTRL_SCALE_BIT] && line_60hz_i;

  always_comb begin
    flag = '0;
    flag[F_SUPLOW] = supply_low_level_i;
    flag[F_BELOWON] = supply_turn_on_level_i;
    flag[F_SUPOV] = supply_ov_i;
    flag[F_LSHORT] = line_short_i;
    flag[F_BRIN] = brownin_low_i;
    flag[F_BROUT] = brownout_i;
    flag[F_LINEOV] = line_ov_i;
    flag[F_OVP] = output_overvoltage_trip_i;
    flag[F_THERM] = temp_trip_i;
    flag[F_VSOV] = sense_overvoltage_off_level_i;
  end

  // each filter only runs in the states where its fault counts
  always_comb begin
    arm = '0;
    // RULE5 supply low watched in every state except reset
    arm[F_SUPLOW] = (q.st != ST_RESET);
    arm[F_BELOWON] = st_pre;
    arm[F_SUPOV] = st_act;
    arm[F_LSHORT] = st_act;
    arm[F_BRIN] = st_pre;
    arm[F_BROUT] = st_act;
    arm[F_LINEOV] = st_act;
    arm[F_OVP] = st_act;
    // RULE1 thermal watched in any active state
    arm[F_THERM] = st_any;
    arm[F_VSOV] = st_act;
  end

  always_comb begin
    // RULE5 supply blanking
    lim[F_SUPLOW] = CNT_W'(CYC_SUPPLY);
    lim[F_BELOWON] = CNT_W'(CYC_SUPPLY);
    lim[F_SUPOV] = CNT_W'(CYC_SUPPLY);
    // RULE7 line blanking
    // a short is not averaged, so it shares the supply count
    lim[F_LSHORT] = CNT_W'(CYC_SUPPLY);
    lim[F_BRIN] = line_scaled ? CNT_W'(LINE60_CYC) : CNT_W'(LINE_CYC);
    lim[F_BROUT] = line_scaled ? CNT_W'(LINE60_CYC) : CNT_W'(LINE_CYC);
    lim[F_LINEOV] = line_scaled ? CNT_W'(LINE60_CYC) : CNT_W'(LINE_CYC);
    lim[F_OVP] = CNT_W'(OVP_CYC);
    lim[F_THERM] = CNT_W'(THERM_CYC);
    lim[F_VSOV] = CNT_W'(VSOV_CYC);
  end

  // ****************************************
  // fault filters
  // ****************************************
  for (genvar i = 0; i < NF; i++) begin : g_blank
    cfs_blank u_blank (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flag_i(flag[i]),
      .arm_i(arm[i]),
      .limit_i(lim[i]),
      .qual_o(qual[i])
    );
  end

  // ****************************************
  // current sense within the gate pulse
  // ****************************************
  logic peak_hit;
  logic hoc_hit;
  logic timed_fault;

  // RULE9 comparator ignored inside leading-edge blanking
  assign peak_hit = st_act && q.gate && (q.on_cnt >= ON_W'(CYC_LEB)) && peak_current_limit_i;
  // RULE10 trip only inside the short window after turn-on
  assign hoc_hit = st_act && q.gate && (q.on_cnt < ON_W'(CYC_HOC)) && hard_overcurrent_trip_i;

  // RULE2 open loop shows up as output overvoltage
  assign timed_fault = qual[F_SUPOV]
                     || qual[F_LSHORT]
                     || qual[F_BROUT]
                     || qual[F_LINEOV]
                     || qual[F_OVP]
                     || hoc_hit;

  logic [CNT_W-1:0] restart_last;
  // fast restart only follows a brownin shortfall in pre-startup
  assign restart_last = q.fast ? CNT_W'(RESTART_FAST_CYC - 1) : CNT_W'(RESTART_CYC - 1);

  // ****************************************
  // register bus decode
  // ****************************************
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] wmask;
  logic [31:0] wbits;

  // one answer per request; the idle cycle after ack blocks a double take
  assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
  // writes land in the ack cycle, at the edge where the master sees its answer
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
  assign bus_rd = bus_req && !wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wbits = wb_dat_i & wmask;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [NEV-1:0] ev;
    logic [NEV-1:0] clr;
    logic [31:0] sts;
    ev = '0;
    clr = '0;
    sts = '0;
    d = q;
    d.ack = bus_req;

    // ---- state flow ----
    unique case (q.st)
      ST_RESET: begin
        d.rst_cnt = '0;
        if (!supply_low_level_i && !supply_turn_on_level_i) begin
          d.st = ST_PRESTART;
        end
      end
      ST_PRESTART: begin
        if (qual[F_THERM]) begin
          d.st = ST_RESTART;
          d.fast = 1'b0;
        // RULE7 brownin gives the fast restart
        end else if (qual[F_BRIN]) begin
          d.st = ST_RESTART;
          d.fast = 1'b1;
        // RULE5 below turn-on waits in reset
        end else if (qual[F_BELOWON]) begin
          d.st = ST_RESET;
        end else if (q.ctrl[CTRL_EN_BIT]) begin
          d.st = ST_SOFT;
        end
      end
      ST_SOFT, ST_RUN: begin
        // RULE1 thermal restart
        if (qual[F_THERM] || timed_fault) begin
          d.st = ST_RESTART;
          d.fast = 1'b0;
        // RULE3 sense overvoltage blocks switching
        end else if (qual[F_VSOV]) begin
          d.st = ST_VSOFF;
        end else if (q.st == ST_SOFT && soft_start_done_i) begin
          d.st = ST_RUN;
        end
      end
      ST_VSOFF: begin
        if (qual[F_THERM]) begin
          d.st = ST_RESTART;
          d.fast = 1'b0;
        // RULE4 resume only below the restart level
        // RULE11 on level sits under off level
        end else if (!sense_overvoltage_on_level_i) begin
          d.st = ST_PRESTART;
        end
      end
      ST_RESTART: begin
        // RULE12 restart delay then pre-startup
        if (q.rst_cnt == restart_last) begin
          d.st = ST_PRESTART;
          d.rst_cnt = '0;
        end else begin
          d.rst_cnt = q.rst_cnt + 1'b1;
        end
      end
      default: begin
        d.st = ST_RESET;
      end
    endcase

    // RULE5 supply low overrides every other outcome
    if (qual[F_SUPLOW]) begin
      d.st = ST_RESET;
    end
    if (d.st != ST_RESTART) begin
      d.rst_cnt = '0;
    end

    // ---- gate pulse ----
    // RULE6 peak cut lasts until the pulse request ends
    if (!pulse_request_i) begin
      d.cut = 1'b0;
    end else if (peak_hit) begin
      d.cut = 1'b1;
    end
    d.gate = pulse_request_i && st_act && (d.st == q.st) && !q.cut && !peak_hit;
    // saturates so a stuck request never wraps back into the window
    if (q.gate) begin
      if (q.on_cnt != {ON_W{1'b1}}) begin
        d.on_cnt = q.on_cnt + 1'b1;
      end
    end else begin
      d.on_cnt = '0;
    end

    // ---- interrupt events ----
    ev[NF-1:0] = qual;
    ev[EV_PEAK] = peak_hit;
    ev[EV_HOC] = hoc_hit;

    // ---- register writes ----
    if (bus_wr) begin
      unique case (wb_adr_i)
        ADDR_CTRL: d.ctrl = (q.ctrl & ~wmask[1:0]) | wbits[1:0];
        ADDR_IRQ_STAT: clr = wbits[NEV-1:0];
        ADDR_IRQ_MASK: d.irq_mask = (q.irq_mask & ~wmask[NEV-1:0]) | wbits[NEV-1:0];
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq = |(d.irq_stat & d.irq_mask);

    // ---- register reads ----
    sts[STS_STATE_LSB +: 3] = q.st;
    sts[STS_GATE_BIT] = q.gate;
    sts[STS_CUT_BIT] = q.cut;
    sts[STS_FAST_BIT] = q.fast;
    sts[STS_QUAL_LSB +: NF] = qual;
    if (bus_rd) begin
      unique case (wb_adr_i)
        ADDR_CTRL: d.rdat = {30'h0000_0000, q.ctrl};
        ADDR_STATUS: d.rdat = sts;
        ADDR_IRQ_STAT: d.rdat = {20'h0_0000, q.irq_stat};
        ADDR_IRQ_MASK: d.rdat = {20'h0_0000, q.irq_mask};
        default: d.rdat = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= ST_RESET;
      q.ctrl <= CTRL_RST;
      q.irq_mask <= MASK_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign irq_o = q.irq;
  assign gate_drive_out_o = q.gate;
  // decoded from the state register, so it adds no lag
  assign core_reset_o = (q.st == ST_RESET);
  assign state_o = q.st;

endmodule

// *** tb/cfs_stage_model.sv ***
// behavioural power stage: current sense comparators seen by the supervisor
`timescale 1ns/1ps
module cfs_stage_model (
  input wire logic clk_i,
  input wire logic gate_i,
  input wire logic [7:0] ramp_i,
  input wire logic short_i,
  output logic peak_o,
  output logic hoc_o
);
  int on_c = 0;
  logic peak_q = 1'b0;
  logic hoc_q = 1'b0;
  assign peak_o = peak_q;
  assign hoc_o = hoc_q;
  // switch-on spike first, then the ramp reaches the limit; no current while the gate is off
  always @(posedge clk_i) begin
    on_c <= gate_i ? on_c + 1 : 0;
    peak_q <= gate_i && (on_c < 4 || on_c >= int'(ramp_i));
    hoc_q <= gate_i && short_i;
  end
endmodule

// *** tb/cfs_supervisor_monitor.sv ***
// port assertions of the converter fault supervisor
`timescale 1ns/1ps
module cfs_supervisor_monitor
  import cfs_pkg::*;
#(
  parameter int unsigned THERM_CYC = CYC_THERM,
  parameter int unsigned VSOV_CYC = CYC_VSOV,
  parameter int unsigned RESTART_CYC = CYC_RESTART,
  parameter int unsigned RESTART_FAST_CYC = CYC_RESTART_FAST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_low_level_i,
  input wire logic sense_overvoltage_on_level_i,
  input wire logic sense_overvoltage_off_level_i,
  input wire logic temp_trip_i,
  input wire logic pulse_request_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic gate_drive_out_o,
  input wire logic core_reset_o,
  input wire logic [2:0] state_o
);
  logic [CNT_W-1:0] sl_c, th_c, vs_c, rs_c, on_c;
  logic run_w;
  assign run_w = state_o == ST_SOFT || state_o == ST_RUN;
  // ****************
  // run lengths
  // ****************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {sl_c, th_c, vs_c, rs_c, on_c} <= '0;
    end else begin
      sl_c <= (supply_low_level_i && !core_reset_o) ? sl_c + 1'b1 : '0;
      th_c <= (temp_trip_i && state_o != ST_RESET && state_o != ST_RESTART) ? th_c + 1'b1 : '0;
      vs_c <= (sense_overvoltage_off_level_i && run_w) ? vs_c + 1'b1 : '0;
      rs_c <= (state_o == ST_RESTART) ? rs_c + 1'b1 : '0;
      on_c <= gate_drive_out_o ? on_c + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rs_left;
    $past(state_o) == ST_RESTART && state_o == ST_PRESTART;
  endsequence
  sequence s_vs_left;
    $past(state_o) == ST_VSOFF && state_o == ST_PRESTART;
  endsequence
  sequence s_pulse_cut;
    $fell(gate_drive_out_o) && run_w && pulse_request_i && $past(pulse_request_i);
  endsequence
  a_core_reset_map: assert property (core_reset_o == (state_o == ST_RESET))
    else $error("core reset disagrees with state");
  a_gate_when_active: assert property (gate_drive_out_o |-> run_w)
    else $error("gate on outside soft start or run");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_supply_low_resets: assert property (sl_c <= CYC_SUPPLY + 3)
    else $error("supply low not followed by reset");
  a_thermal_restarts: assert property (th_c <= THERM_CYC + 3)
    else $error("thermal trip not followed by restart");
  a_sense_ov_stops: assert property (vs_c <= VSOV_CYC + 3)
    else $error("sense overvoltage did not stop switching");
  a_restart_len_max: assert property (rs_c <= RESTART_CYC + 3)
    else $error("restart delay too long");
  a_restart_len_min: assert property (s_rs_left |-> $past(rs_c) + 2 >= RESTART_FAST_CYC)
    else $error("restart delay too short");
  a_vsoff_exit_level: assert property (s_vs_left |-> !$past(sense_overvoltage_on_level_i))
    else $error("left sense shutdown above restart level");
  a_leb_blank_peak: assert property (s_pulse_cut |-> $past(on_c) >= CYC_LEB)
    else $error("pulse cut inside leading edge blanking");
endmodule

bind cfs_supervisor cfs_supervisor_monitor #(.THERM_CYC(THERM_CYC), .VSOV_CYC(VSOV_CYC), .RESTART_CYC(RESTART_CYC),
  .RESTART_FAST_CYC(RESTART_FAST_CYC)) u_monitor (.clk_i, .rst_i, .supply_low_level_i, .sense_overvoltage_on_level_i,
  .sense_overvoltage_off_level_i, .temp_trip_i, .pulse_request_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .gate_drive_out_o, .core_reset_o, .state_o);

// *** tb/converter_fault_supervisor_test.sv ***
// self-checking bench of the converter fault supervisor
`timescale 1ns/1ps
module converter_fault_supervisor_test
  import cfs_pkg::*;
;
  localparam int TH = 20;
  localparam int OV = 30;
  localparam int VS = 25;
  localparam int LN = 60;
  localparam int RS = 40;
  localparam int RF = 10;
  localparam int LS = LN * LINE60_NUM / LINE60_DEN;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [NF-1:0] flt = '0;
  logic hz60 = 1'b0;
  logic sense_on = 1'b0;
  logic preq = 1'b0;
  logic ssd = 1'b1;
  logic shrt = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [7:0] ramp = 8'h3C;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd, dat_o;
  logic ack, irq, gate, crst, peak, hoc;
  logic [2:0] st;
  int fails = 0;
  int num_checks = 0;
  int seed = 32'hAFFB;
  int n;
  int fi[7] = '{F_SUPOV, F_LSHORT, F_BROUT, F_LINEOV, F_OVP, F_THERM, F_BROUT};
  int fl[7] = '{CYC_SUPPLY, CYC_SUPPLY, LN, LN, OV, TH, LS};

  cfs_supervisor #(.THERM_CYC(TH), .OVP_CYC(OV), .VSOV_CYC(VS), .LINE_CYC(LN), .RESTART_CYC(RS),
    .RESTART_FAST_CYC(RF)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .supply_low_level_i(flt[F_SUPLOW]), .supply_turn_on_level_i(flt[F_BELOWON]),
    .supply_ov_i(flt[F_SUPOV]), .line_short_i(flt[F_LSHORT]), .brownin_low_i(flt[F_BRIN]),
    .brownout_i(flt[F_BROUT]), .line_ov_i(flt[F_LINEOV]), .line_60hz_i(hz60), .peak_current_limit_i(peak),
    .hard_overcurrent_trip_i(hoc), .output_overvoltage_trip_i(flt[F_OVP]),
    .sense_overvoltage_off_level_i(flt[F_VSOV]), .sense_overvoltage_on_level_i(sense_on),
    .temp_trip_i(flt[F_THERM]), .pulse_request_i(preq), .soft_start_done_i(ssd), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .irq_o(irq), .gate_drive_out_o(gate), .core_reset_o(crst), .state_o(st));
  cfs_stage_model stage (.clk_i(clk_i), .gate_i(gate), .ramp_i(ramp), .short_i(shrt), .peak_o(peak), .hoc_o(hoc));

  always #2 clk_i = ~clk_i;

  // ****************
  // helpers
  // ****************
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = dat_o;
    chk(ack === 1'b1, "no bus answer");
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(st === s, "state not reached");
  endtask
  task automatic wait_gate(input logic v, input int lim);
    n = 0;
    while (gate !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(gate === v, "gate level");
  endtask
  // the flag is dropped as soon as the reaction shows, so it cannot trip twice
  task automatic trip(input int i, input logic [2:0] s, input int lim);
    flt[i] <= 1'b1;
    wait_st(s, lim + 10);
    chk(n >= lim + 2 && n <= lim + 4, "blanking time");
    flt[i] <= 1'b0;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    finish_test();
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(crst === 1'b1 && st === 3'h0 && gate === 1'b0, "reset state");
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd === 32'h1, "ctrl reset value");
    bus(1'b0, 8'h10, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    wait_st(ST_RUN, 50);
    ramp <= 8'(45 + ($random(seed) & 15));
    preq <= 1'b1;
    wait_gate(1'b1, 5);
    wait_gate(1'b0, 80);
    chk(n >= int'(ramp) && n <= int'(ramp) + 4, "pulse cut time");
    chk(st === ST_RUN, "restart on peak current");
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[STS_CUT_BIT] === 1'b1 && gate === 1'b0, "pulse not held off");
    preq <= 1'b0;
    bus(1'b1, ADDR_IRQ_MASK, 32'h400);
    chk(irq === 1'b1, "irq not raised");
    bus(1'b1, ADDR_IRQ_STAT, 32'h400);
    chk(irq === 1'b0, "irq not cleared");
    for (int i = 0; i < 7; i++) begin
      if (i == 6) begin
        bus(1'b1, ADDR_CTRL, 32'h3);
      end
      hz60 <= (i == 6) ? 1'b1 : 1'($random(seed));
      trip(fi[i], ST_RESTART, fl[i]);
      wait_st(ST_PRESTART, RS + 20);
      chk(n >= RS && n <= RS + 4, "restart delay");
      wait_st(ST_RUN, 20);
    end
    sense_on <= 1'b1;
    trip(F_VSOV, ST_VSOFF, VS);
    repeat (20) @(posedge clk_i);
    chk(st === ST_VSOFF && gate === 1'b0, "left shutdown above restart level");
    sense_on <= 1'b0;
    wait_st(ST_PRESTART, 5);
    wait_st(ST_RUN, 20);
    {shrt, preq} <= 2'b11;
    wait_st(ST_RESTART, 10);
    {shrt, preq} <= 2'b00;
    wait_st(ST_PRESTART, RS + 20);
    wait_st(ST_RUN, 20);
    bus(1'b1, ADDR_CTRL, 32'h2);
    trip(F_SUPLOW, ST_RESET, CYC_SUPPLY);
    wait_st(ST_PRESTART, 10);
    trip(F_BELOWON, ST_RESET, CYC_SUPPLY);
    wait_st(ST_PRESTART, 10);
    trip(F_BRIN, ST_RESTART, LS);
    wait_st(ST_PRESTART, RS + 20);
    chk(n >= RF && n <= RF + 4, "fast restart delay");
    finish_test();
  end
endmodule
